// >>> logic/rtcie_params.svh
`ifndef RTCIE_PARAMS_SVH
`define RTCIE_PARAMS_SVH

// Register indices (low nibble of the byte address)
`define RTCIE_IDX_MIN 4'h1
`define RTCIE_IDX_HOUR 4'h2
`define RTCIE_IDX_WDAY 4'h3
`define RTCIE_IDX_DATE 4'h4
`define RTCIE_IDX_AL_MIN 4'h8
`define RTCIE_IDX_AL_HOUR 4'h9
`define RTCIE_IDX_AL_DAY 4'ha
`define RTCIE_IDX_TC0 4'hb
`define RTCIE_IDX_TC1 4'hc
`define RTCIE_IDX_EXT 4'hd
`define RTCIE_IDX_FLAG 4'he
`define RTCIE_IDX_CTRL 4'hf
`define RTCIE_IDX_MIRROR_FIRST 4'hb

// Field positions
`define RTCIE_EXT_ALARM_TARGET_SELECT 6
`define RTCIE_EXT_UPDATE_PERIOD_SELECT 5
`define RTCIE_EXT_TE 4
`define RTCIE_EXT_TSEL_HI 1
`define RTCIE_EXT_TSEL_LO 0
`define RTCIE_FLG_UF 5
`define RTCIE_FLG_TF 4
`define RTCIE_FLG_AF 3
`define RTCIE_CTL_UIE 5
`define RTCIE_CTL_TIE 4
`define RTCIE_CTL_AIE 3
`define RTCIE_CTL_RST 0
`define RTCIE_ALM_MASK 7
`define RTCIE_CTRL_WMASK 8'hf9

// Reset values
`define RTCIE_RST_EXT 8'h00
`define RTCIE_RST_CTRL 8'h40
`define RTCIE_RST_TIME 8'h00
`define RTCIE_RST_DAY 8'h01

// Timing
`define RTCIE_CLK_HZ 50000000
`define RTCIE_CLK_PERIOD_NS 20
`define RTCIE_TICK_HZ 4096
`define RTCIE_TICK_DIV (`RTCIE_CLK_HZ / `RTCIE_TICK_HZ)
`define RTCIE_RTN_NS 7813000
`define RTCIE_RTN_FAST_NS 122000
`define RTCIE_RTN_CYC ((`RTCIE_RTN_NS + `RTCIE_CLK_PERIOD_NS - 1) / `RTCIE_CLK_PERIOD_NS)
`define RTCIE_RTN_FAST_CYC \
   ((`RTCIE_RTN_FAST_NS + `RTCIE_CLK_PERIOD_NS - 1) / `RTCIE_CLK_PERIOD_NS)
`define RTCIE_RTN_W 19
`define RTCIE_DIV_W 16
`define RTCIE_T64_LAST 6'h3f
`define RTCIE_SUB_LAST 12'hfff
`define RTCIE_SEC_LAST 6'h3b

// Bus address, arbitrary value
`define RTCIE_DEV_ADDR 7'h5a

`endif

// >>> logic/rtcie_pkg.sv
`default_nettype none
`include "rtcie_params.svh"
package rtcie_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } rtcie_wr_t;

   typedef logic [15:0][7:0] rtcie_img_t;

   typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_PTR, LK_WDATA, LK_RDATA} rtcie_lphase_t;

   typedef struct packed {
      rtcie_lphase_t phase;
      logic [3:0] bitcnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic [7:0] ptr;
      logic rw;
      logic ack;
      logic seen;
      logic wr_tog;
      rtcie_wr_t wr;
      rtcie_img_t img_s1;
      rtcie_img_t img_s2;
   } rtcie_link_st_t;

   typedef struct packed {
      logic tog_s1;
      logic tog_s2;
      logic tog_s3;
      logic tog_seen;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] date;
      logic [7:0] al_min;
      logic [7:0] al_hour;
      logic [7:0] al_day;
      logic [7:0] tc0;
      logic [7:0] tc1;
      logic [7:0] ext;
      logic [7:0] ctrl;
      logic uf;
      logic tf;
      logic af;
      logic [`RTCIE_DIV_W-1:0] div;
      logic [5:0] t64;
      logic [11:0] sub;
      logic [5:0] secs;
      logic [11:0] tcnt;
      logic tlow;
      logic ulow;
      logic alow;
      logic [`RTCIE_RTN_W-1:0] tl_cnt;
      logic [`RTCIE_RTN_W-1:0] ul_cnt;
      logic int_oe_n;
   } rtcie_main_st_t;

   // Returns {valid, index}; mirrors at +0x10 exist for time and control registers
   function automatic logic [4:0] rtcie_reg_idx(input logic [7:0] a);
      logic ok;
      ok = (a[7:5] == 3'h0) &&
           ((a[3:0] >= `RTCIE_IDX_MIN && a[3:0] <= `RTCIE_IDX_DATE) ||
            (a[3:0] >= `RTCIE_IDX_MIRROR_FIRST) ||
            (!a[4] && a[3:0] >= `RTCIE_IDX_AL_MIN));
      return {ok, a[3:0]};
   endfunction : rtcie_reg_idx
endpackage : rtcie_pkg
`default_nettype wire

// >>> logic/rtcie_link.sv
`default_nettype none
`include "rtcie_params.svh"
// Serial bus slave on the serial clock; writes leave by toggle, reads use a synced image
module rtcie_link #(
   parameter logic [6:0] DEV_ADDR = `RTCIE_DEV_ADDR
) (
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic srst,
   input wire rtcie_pkg::rtcie_img_t img,
   output logic wr_tog,
   output rtcie_pkg::rtcie_wr_t wr,
   output logic sda_o,
   output logic sda_oe_n
);
   rtcie_pkg::rtcie_link_st_t r;
   rtcie_pkg::rtcie_link_st_t n;
   logic start_tog_r;
   logic [7:0] byte_in;

   function automatic logic [7:0] rd_at(input rtcie_pkg::rtcie_img_t im, input logic [7:0] a);
      logic [4:0] v;
      v = rtcie_pkg::rtcie_reg_idx(a);
      return v[4] ? im[v[3:0]] : 8'h00;
   endfunction : rd_at

   // Start condition: data falls while clock is high
   always_ff @(negedge sda_i or posedge srst) begin
      if (srst) begin
         start_tog_r <= 1'b0;
      end else if (scl_i) begin
         start_tog_r <= ~start_tog_r;
      end
   end

   always_comb begin
      n = r;
      byte_in = {r.rx[6:0], sda_i};
      n.img_s1 = img;
      n.img_s2 = r.img_s1;
      if (start_tog_r != r.seen) begin
         n.seen = start_tog_r;
         n.phase = rtcie_pkg::LK_ADDR;
         n.bitcnt = 4'h1;
         n.rx = {7'h00, sda_i};
         n.ack = 1'b0;
      end else if (r.phase != rtcie_pkg::LK_IDLE) begin
         if (r.bitcnt != 4'h8) begin
            n.rx = byte_in;
            n.tx = {r.tx[6:0], 1'b0};
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == 4'h7) begin
               case (r.phase)
                  rtcie_pkg::LK_ADDR: begin
                     n.ack = (byte_in[7:1] == DEV_ADDR);
                     n.rw = byte_in[0];
                     if (byte_in[7:1] != DEV_ADDR) begin
                        n.phase = rtcie_pkg::LK_IDLE;
                     end
                  end
                  rtcie_pkg::LK_PTR: begin
                     n.ptr = byte_in;
                     n.ack = 1'b1;
                  end
                  rtcie_pkg::LK_WDATA: begin
                     n.wr.addr = r.ptr;
                     n.wr.data = byte_in;
                     n.wr_tog = ~r.wr_tog;
                     n.ptr = r.ptr + 8'h01;
                     n.ack = 1'b1;
                  end
                  default: n.ack = 1'b0;
               endcase
            end
         end else begin
            n.bitcnt = 4'h0;
            n.ack = 1'b0;
            case (r.phase)
               rtcie_pkg::LK_ADDR: begin
                  n.phase = r.rw ? rtcie_pkg::LK_RDATA : rtcie_pkg::LK_PTR;
                  n.tx = rd_at(r.img_s2, r.ptr);
               end
               rtcie_pkg::LK_PTR: n.phase = rtcie_pkg::LK_WDATA;
               rtcie_pkg::LK_RDATA: begin
                  if (sda_i) begin
                     n.phase = rtcie_pkg::LK_IDLE;
                  end else begin
                     n.ptr = r.ptr + 8'h01;
                     n.tx = rd_at(r.img_s2, r.ptr + 8'h01);
                  end
               end
               default: n.phase = r.phase;
            endcase
         end
      end
   end

   always_ff @(posedge scl_i or posedge srst) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Data line changes only while the clock is low
   always_ff @(negedge scl_i or posedge srst) begin
      if (srst) begin
         sda_o <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         sda_o <= 1'b0;
         sda_oe_n <= ~((r.bitcnt == 4'h8 && r.ack) ||
                       (r.phase == rtcie_pkg::LK_RDATA && r.bitcnt != 4'h8 && !r.tx[7]));
      end
   end

   assign wr_tog = r.wr_tog;
   assign wr = r.wr;
endmodule : rtcie_link
`default_nettype wire

// >>> logic/rtcie_top.sv
// Summary of operation
// - Timer flag sets on timer event, holds until written 0; writing 1 ignored.
// - Timer event with timer enable set pulls the interrupt line low.
// - Clearing timer enable while line low releases it.
// - Timer-driven low releases by itself after the release time.
// - Period is count times source period; count 0 gives no events.
// - Countdown starts at the clock edge ending the enabling write.
// - Update event each second, or each minute when period select is 1.
// - Update flag sets on each update event, clears only by writing 0.
// - Update event pulls line low only when update enable set.
// - Update-driven low lasts the fixed release time, reasserts next event.
// - Clearing timer or update flag never changes the line.
// - Clearing update enable while its low is active releases at once.
// - Reset-control bit set suppresses update events.
// - Update source runs unless reset-control bit set; enable only gates the line.
// - Alarm event sets flag; with enable, line held low until cleared.
// - Alarm equal to present time waits for the next count-up.
// - Clearing alarm enable releases an alarm-held low at once.
// - Clearing alarm flag releases an alarm-held low at once.
// - Alarm with enable clear sets flag, line stays released.
// - One line shared by three sources; any enabled one may pull low.
// - Unused flag bits and control bits 2,1 read 0; flags and enables at bits 5,4,3.
// - Time registers hold BCD, weekday one bit per day, mirrored at +0x10.
// - Timer counts down, fires stepping 1 to 0, reloads and repeats.
// - Timer release time is short for the fastest source, long otherwise.
// - Alarm matches minute, hour, and weekday or date; mask bit 1 ignores a field.
`default_nettype none
`include "rtcie_params.svh"
module rtcie_top #(
   parameter logic [`RTCIE_DIV_W-1:0] TICK_DIV = `RTCIE_DIV_W'(`RTCIE_TICK_DIV),
   parameter logic [`RTCIE_RTN_W-1:0] RTN_CYC = `RTCIE_RTN_W'(`RTCIE_RTN_CYC),
   parameter logic [`RTCIE_RTN_W-1:0] RTN_FAST_CYC = `RTCIE_RTN_W'(`RTCIE_RTN_FAST_CYC),
   parameter logic [6:0] DEV_ADDR = `RTCIE_DEV_ADDR
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   output logic int_o,
   output logic int_oe_n
);
   rtcie_pkg::rtcie_main_st_t r;
   rtcie_pkg::rtcie_main_st_t n;
   rtcie_pkg::rtcie_img_t img;
   rtcie_pkg::rtcie_wr_t wr;
   logic wr_tog;
   logic wr_ev;
   logic [4:0] widx;
   logic tick;
   logic t64_tick;
   logic sec_tick;
   logic min_tick;
   logic src_tick;
   logic upd_ev;
   logic tmr_ev;
   logic alm_ev;
   logic [11:0] preset;
   logic clr_uf;
   logic clr_tf;
   logic clr_af;
   logic m_ok;
   logic h_ok;
   logic d_ok;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return {v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   rtcie_link #(
      .DEV_ADDR(DEV_ADDR)
   ) u_link (
      .scl_i(scl_i),
      .sda_i(sda_i),
      .srst(srst),
      .img(img),
      .wr_tog(wr_tog),
      .wr(wr),
      .sda_o(sda_o),
      .sda_oe_n(sda_oe_n)
   );

   // Read image; unused time and flag bits read as zero
   always_comb begin
      img = '0;
      img[`RTCIE_IDX_MIN] = {1'b0, r.min[6:0]};
      img[`RTCIE_IDX_HOUR] = {2'b00, r.hour[5:0]};
      img[`RTCIE_IDX_WDAY] = {1'b0, r.wday[6:0]};
      img[`RTCIE_IDX_DATE] = {2'b00, r.date[5:0]};
      img[`RTCIE_IDX_AL_MIN] = r.al_min;
      img[`RTCIE_IDX_AL_HOUR] = r.al_hour;
      img[`RTCIE_IDX_AL_DAY] = r.al_day;
      img[`RTCIE_IDX_TC0] = r.tc0;
      img[`RTCIE_IDX_TC1] = r.tc1;
      img[`RTCIE_IDX_EXT] = r.ext;
      img[`RTCIE_IDX_FLAG] = {2'b00, r.uf, r.tf, r.af, 3'b000};
      img[`RTCIE_IDX_CTRL] = r.ctrl;
   end

   always_comb begin
      n = r;
      n.tog_s1 = wr_tog;
      n.tog_s2 = r.tog_s1;
      n.tog_s3 = r.tog_s2;
      wr_ev = (r.tog_s2 == r.tog_s3) && (r.tog_s3 != r.tog_seen);
      if (wr_ev) begin
         n.tog_seen = r.tog_s3;
      end
      widx = rtcie_pkg::rtcie_reg_idx(wr.addr);
      clr_uf = wr_ev && widx == {1'b1, `RTCIE_IDX_FLAG} && !wr.data[`RTCIE_FLG_UF];
      clr_tf = wr_ev && widx == {1'b1, `RTCIE_IDX_FLAG} && !wr.data[`RTCIE_FLG_TF];
      clr_af = wr_ev && widx == {1'b1, `RTCIE_IDX_FLAG} && !wr.data[`RTCIE_FLG_AF];

      // Time base: 4096 Hz tick, 64 Hz, second and minute
      tick = (r.div == TICK_DIV - `RTCIE_DIV_W'(1));
      n.div = tick ? '0 : r.div + `RTCIE_DIV_W'(1);
      t64_tick = tick && (r.t64 == `RTCIE_T64_LAST);
      if (tick) begin
         n.t64 = r.t64 + 6'h01;
      end
      sec_tick = tick && (r.sub == `RTCIE_SUB_LAST) && !r.ctrl[`RTCIE_CTL_RST];
      if (r.ctrl[`RTCIE_CTL_RST]) begin
         n.sub = 12'h000;
      end else if (tick) begin
         n.sub = r.sub + 12'h001;
      end
      min_tick = sec_tick && (r.secs == `RTCIE_SEC_LAST);
      if (sec_tick) begin
         n.secs = min_tick ? 6'h00 : r.secs + 6'h01;
      end
      // Runs regardless of the enable
      upd_ev = r.ext[`RTCIE_EXT_UPDATE_PERIOD_SELECT] ? min_tick : sec_tick;

      // Calendar roll in BCD
      if (min_tick) begin
         n.min = (r.min[6:0] == 7'h59) ? 8'h00 : bcd_inc(r.min);
         if (r.min[6:0] == 7'h59) begin
            n.hour = (r.hour[5:0] == 6'h23) ? 8'h00 : bcd_inc(r.hour);
            if (r.hour[5:0] == 6'h23) begin
               n.wday = {1'b0, r.wday[5:0], r.wday[6]};
               n.date = (r.date[5:0] == 6'h31) ? 8'h01 : bcd_inc(r.date);
            end
         end
      end

      // Alarm compares only when the clock counts up
      m_ok = r.al_min[`RTCIE_ALM_MASK] || (r.al_min[6:0] == n.min[6:0]);
      h_ok = r.al_hour[`RTCIE_ALM_MASK] || (r.al_hour[5:0] == n.hour[5:0]);
      if (r.ext[`RTCIE_EXT_ALARM_TARGET_SELECT]) begin
         d_ok = r.al_day[`RTCIE_ALM_MASK] || (r.al_day[5:0] == n.date[5:0]);
      end else begin
         d_ok = r.al_day[`RTCIE_ALM_MASK] || ((r.al_day[6:0] & n.wday[6:0]) != 7'h00);
      end
      alm_ev = min_tick && m_ok && h_ok && d_ok;

      // Fixed-cycle countdown
      preset = {r.tc1[3:0], r.tc0};
      case ({r.ext[`RTCIE_EXT_TSEL_HI], r.ext[`RTCIE_EXT_TSEL_LO]})
         2'b00: src_tick = tick;
         2'b01: src_tick = t64_tick;
         2'b10: src_tick = sec_tick;
         default: src_tick = min_tick;
      endcase
      tmr_ev = 1'b0;
      if (r.ext[`RTCIE_EXT_TE] && src_tick && r.tcnt != 12'h000) begin
         if (r.tcnt == 12'h001) begin
            tmr_ev = 1'b1;
            n.tcnt = preset;
         end else begin
            n.tcnt = r.tcnt - 12'h001;
         end
      end

      // Register writes; alarm registers have no mirror
      if (wr_ev && widx[4]) begin
         case (widx[3:0])
            `RTCIE_IDX_MIN: n.min = {1'b0, wr.data[6:0]};
            `RTCIE_IDX_HOUR: n.hour = {2'b00, wr.data[5:0]};
            `RTCIE_IDX_WDAY: n.wday = {1'b0, wr.data[6:0]};
            `RTCIE_IDX_DATE: n.date = {2'b00, wr.data[5:0]};
            `RTCIE_IDX_AL_MIN: n.al_min = wr.data;
            `RTCIE_IDX_AL_HOUR: n.al_hour = wr.data;
            `RTCIE_IDX_AL_DAY: n.al_day = wr.data;
            `RTCIE_IDX_TC0: n.tc0 = wr.data;
            `RTCIE_IDX_TC1: n.tc1 = wr.data;
            `RTCIE_IDX_EXT: begin
               n.ext = wr.data;
               if (wr.data[`RTCIE_EXT_TE] && !r.ext[`RTCIE_EXT_TE]) begin
                  n.tcnt = preset;
               end
            end
            `RTCIE_IDX_CTRL: n.ctrl = wr.data & `RTCIE_CTRL_WMASK;
            default: n.ctrl = n.ctrl;
         endcase
      end

      // Flags: set beats clear, writing 1 does nothing
      n.uf = (r.uf && !clr_uf) || upd_ev;
      n.tf = (r.tf && !clr_tf) || tmr_ev;
      n.af = (r.af && !clr_af) || alm_ev;

      // Timer low: self-release, cancelled by enable or run bit clearing
      if (tmr_ev && n.ctrl[`RTCIE_CTL_TIE]) begin
         n.tlow = 1'b1;
         n.tl_cnt = (n.ext[1:0] == 2'b00) ? RTN_FAST_CYC : RTN_CYC;
      end else if (r.tlow) begin
         if (r.tl_cnt <= `RTCIE_RTN_W'(1)) begin
            n.tlow = 1'b0;
         end else begin
            n.tl_cnt = r.tl_cnt - `RTCIE_RTN_W'(1);
         end
      end
      if (!n.ctrl[`RTCIE_CTL_TIE] || !n.ext[`RTCIE_EXT_TE]) begin
         n.tlow = 1'b0;
      end

      // Update low: fixed release time, enable clear cancels
      if (upd_ev && n.ctrl[`RTCIE_CTL_UIE]) begin
         n.ulow = 1'b1;
         n.ul_cnt = RTN_CYC;
      end else if (r.ulow) begin
         if (r.ul_cnt <= `RTCIE_RTN_W'(1)) begin
            n.ulow = 1'b0;
         end else begin
            n.ul_cnt = r.ul_cnt - `RTCIE_RTN_W'(1);
         end
      end
      if (!n.ctrl[`RTCIE_CTL_UIE]) begin
         n.ulow = 1'b0;
      end

      // Alarm low is a level of flag and enable, no auto release
      n.alow = n.af && n.ctrl[`RTCIE_CTL_AIE];

      // Flag clears do not enter the timer or update lows
      n.int_oe_n = !(n.tlow || n.ulow || n.alow);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
         r.min <= `RTCIE_RST_TIME;
         r.hour <= `RTCIE_RST_TIME;
         r.wday <= `RTCIE_RST_DAY;
         r.date <= `RTCIE_RST_DAY;
         r.ext <= `RTCIE_RST_EXT;
         r.ctrl <= `RTCIE_RST_CTRL;
         r.int_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign int_o = 1'b0;
   assign int_oe_n = r.int_oe_n;
endmodule : rtcie_top
`default_nettype wire

// >>> tb/rtcie_props.sv
`default_nettype none
`include "rtcie_params.svh"
module rtcie_props #(
   parameter logic [`RTCIE_RTN_W-1:0] RTN_FAST_CYC = `RTCIE_RTN_W'(`RTCIE_RTN_FAST_CYC)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic int_o,
   input wire logic int_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // Cycles since the serial clock last moved, and length of the current low run
   logic [`RTCIE_RTN_W-1:0] quiet_r;
   logic [`RTCIE_RTN_W-1:0] low_r;
   logic scl_q_r;
   always_ff @(posedge clk) begin
      scl_q_r <= scl_i;
      quiet_r <= (srst || scl_i != scl_q_r) ? '0 : quiet_r + 1'b1;
      low_r <= (srst || int_oe_n) ? '0 : low_r + 1'b1;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   a_int_drive_zero: assert property (int_o == 1'b0)
      else $error("interrupt drive value not zero");
   a_sda_drive_zero: assert property (sda_o == 1'b0)
      else $error("data drive value not zero");
   a_sda_after_reset: assert property ($fell(srst) |-> sda_oe_n)
      else $error("data line held after reset");
   a_quiet_start: assert property ($fell(srst) |-> int_oe_n [*8])
      else $error("interrupt low right after reset");
   a_low_min_hold: assert property ($rose(int_oe_n) && quiet_r > low_r + 19'h8
      |-> low_r >= RTN_FAST_CYC - 1'b1)
      else $error("interrupt low released too early");
   a_low_min_rep: assert property ($fell(int_oe_n) && quiet_r > 19'h8
      |-> !int_oe_n [*6])
      else $error("interrupt low run too short");
   a_low_hold_next: assert property (!int_oe_n && low_r + 19'h2 < RTN_FAST_CYC
      && quiet_r > low_r + 19'h8 |=> !int_oe_n)
      else $error("interrupt low dropped with no bus access");
   a_sda_idle_free: assert property (scl_i [*4] |-> sda_oe_n)
      else $error("data line held while bus idle");
endmodule : rtcie_props
bind rtcie_top rtcie_props #(.RTN_FAST_CYC(RTN_FAST_CYC)) u_props (
   .clk(clk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n(sda_oe_n), .int_o(int_o), .int_oe_n(int_oe_n));
`default_nettype wire

// >>> tb/rtcie_host.sv
`default_nettype none
`include "rtcie_params.svh"
// Bus master; the serial clock stands high between frames
module rtcie_host (
   output logic scl,
   output logic sda_m,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic nak;
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // One 32 ns bit; data moves only while the clock is low
   task automatic slot(input logic b, output logic s);
      sda_m = b;
      #8 scl = 1'b1;
      #8 s = sda_line;
      #8 scl = 1'b0;
      #8;
   endtask : slot
   task automatic start();
      sda_m = 1'b1;
      #8 scl = 1'b1;
      #16 sda_m = 1'b0;
      #16 scl = 1'b0;
      #8;
   endtask : start
   task automatic stop();
      sda_m = 1'b0;
      #8 scl = 1'b1;
      #16 sda_m = 1'b1;
      #16;
   endtask : stop
   task automatic put(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) slot(b[i], s);
      slot(1'b1, nak);
   endtask : put
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      put({`RTCIE_DEV_ADDR, 1'b0});
      put(a);
      put(d);
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      start();
      put({`RTCIE_DEV_ADDR, 1'b0});
      put(a);
      start();
      put({`RTCIE_DEV_ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
      slot(1'b1, nak);
      stop();
   endtask : rd
endmodule : rtcie_host
`default_nettype wire

// >>> tb/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DIV = 4;
   localparam int FAST = 8;
   localparam int RTN = 200;
   localparam int SEC = 4096 * DIV;
   logic clk;
   logic srst;
   logic scl;
   logic sda_m;
   logic sda_o;
   logic sda_oe_n;
   logic int_o;
   logic int_oe_n;
   wire logic sda_line;
   int n_errors;
   int compares;
   int t;
   logic [7:0] v;
   logic [7:0] rd;
   logic [7:0] ra [8] = '{8'h01, 8'h03, 8'h04, 8'h14, 8'h0d, 8'h0e, 8'h0f, 8'h05};
   logic [7:0] rv [8] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h40, 8'h00};
   // Pull-up on the data line
   assign sda_line = sda_m & (sda_oe_n | sda_o);
   rtcie_top #(.TICK_DIV(16'(DIV)), .RTN_CYC(19'(RTN)), .RTN_FAST_CYC(19'(FAST))) uut (
      .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .int_o(int_o), .int_oe_n(int_oe_n));
   rtcie_host host (.scl(scl), .sda_m(sda_m), .sda_line(sda_line));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic int exp_per(input int n, input logic slow);
      return n * DIV * (slow ? 64 : 1);
   endfunction : exp_per
   function automatic logic [7:0] exp_ctrl(input logic [7:0] w);
      return w & 8'hf9;
   endfunction : exp_ctrl
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp8
   task automatic cmpn(input string what, input int exp, input int got);
      compares++;
      if (got != exp) begin
         n_errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask : cmpn
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      cmp8("ack", 8'h00, {7'h00, host.nak});
      repeat (8) @(negedge clk);
   endtask : wr
   task automatic rdr(input string what, input logic [7:0] a, input logic [7:0] exp);
      repeat (4) @(negedge clk);
      host.rd(a, rd);
      cmp8(what, exp, rd);
   endtask : rdr
   task automatic wait_int(input logic lvl, input int lim, output int n);
      n = 0;
      while (int_oe_n !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_int
   task automatic summarize();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   initial begin
      #1900us;
      n_errors++;
      summarize();
   end
   initial begin
      n_errors = 0;
      compares = 0;
      // Rise after time zero so the asynchronous link reset is seen
      srst = 1'b0;
      #1 srst = 1'b1;
      void'($urandom(32'hbf80dea8));
      repeat (5) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      foreach (ra[i]) rdr("reset", ra[i], rv[i]);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         wr(8'h0b, v);
         rdr("tcnt", 8'h1b, v);
         v = v & 8'hc6;
         wr(8'h1f, v);
         rdr("ctrl", 8'h0f, exp_ctrl(v));
      end
      wr(8'h0e, 8'hff);
      rdr("flag1", 8'h0e, 8'h00);
      v = 8'(5 + $urandom % 4);
      wr(8'h0b, v);
      wr(8'h0c, 8'h00);
      wr(8'h0f, 8'h50);
      wr(8'h0d, 8'h10);
      wait_int(1'b0, 200, t);
      wait_int(1'b1, 50, t);
      cmpn("tlow", FAST, t);
      wait_int(1'b0, 200, t);
      cmpn("tper", exp_per(int'(v), 1'b0), FAST + t);
      rdr("tflag", 8'h0e, 8'h10);
      wr(8'h0f, 8'h40);
      wait_int(1'b0, 100, t);
      cmpn("notie", 100, t);
      wr(8'h0d, 8'h00);
      wr(8'h0e, 8'h00);
      rdr("tclr", 8'h0e, 8'h00);
      wr(8'h0b, 8'h00);
      wr(8'h0d, 8'h10);
      repeat (100) @(negedge clk);
      rdr("zero", 8'h0e, 8'h00);
      wr(8'h0d, 8'h00);
      wr(8'h0b, 8'h02);
      wr(8'h0f, 8'h50);
      wr(8'h0d, 8'h11);
      wait_int(1'b0, exp_per(3, 1'b1), t);
      wr(8'h0e, 8'h00);
      cmp8("keep", 8'h00, {7'h00, int_oe_n});
      wr(8'h0f, 8'h40);
      cmp8("tie0", 8'h01, {7'h00, int_oe_n});
      wr(8'h0d, 8'h00);
      wr(8'h0e, 8'h00);
      wr(8'h0d, 8'h00);
      wr(8'h0f, 8'h60);
      wait_int(1'b0, SEC + 100, t);
      wait_int(1'b1, RTN + 10, t);
      cmpn("ulow", RTN, t);
      wait_int(1'b0, SEC, t);
      cmpn("uper", SEC, RTN + t);
      wr(8'h0f, 8'h40);
      cmp8("uie0", 8'h01, {7'h00, int_oe_n});
      rdr("uflag", 8'h0e, 8'h20);
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'h61);
      wait_int(1'b0, SEC + 100, t);
      cmpn("rstblk", SEC + 100, t);
      rdr("rflag", 8'h0e, 8'h00);
      wr(8'h0f, 8'h40);
      // Second-source timer with count 1 fires at the next second, line stays released
      wr(8'h0b, 8'h01);
      wr(8'h0d, 8'h12);
      wait_int(1'b0, SEC + 100, t);
      cmpn("gated", SEC + 100, t);
      rdr("free", 8'h0e, 8'h30);
      summarize();
   end
endmodule : testbench
`default_nettype wire
